// *** hw/tsq_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the trigger sequencer.
// Assumes a 250 MHz hclk and byte addresses on a 32-bit AHB-Lite bus.
`ifndef TSQ_REGS_SVH
`define TSQ_REGS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define TSQ_CTRL_OFS 8'h00
`define TSQ_STAT_OFS 8'h04
`define TSQ_CNT1_CFG_OFS 8'h08
`define TSQ_CNT2_CFG_OFS 8'h0C
`define TSQ_CNT1_VAL_OFS 8'h10
`define TSQ_CNT2_VAL_OFS 8'h14
`define TSQ_PAT_BASE 8'h20
`define TSQ_CLAUSE_BASE 8'h40
// ****************************************
// Field positions
// ****************************************
`define TSQ_CTRL_START 0
`define TSQ_CTRL_ABORT 1
`define TSQ_CTRL_POS_LSB 2
`define TSQ_CFG_UNIT_LSB 0
`define TSQ_CFG_CMP_LSB 8
`define TSQ_CL_USED 0
`define TSQ_CL_SEL_LSB 1
`define TSQ_CL_INV 4
`define TSQ_CL_BRK 5
`define TSQ_CL_DBL 6
`define TSQ_CL_TRIG 7
`define TSQ_CL_JUMP 8
`define TSQ_CL_TGT_LSB 9
`define TSQ_CL_C1_LSB 12
`define TSQ_CL_C1_EXEC 14
`define TSQ_CL_C2_LSB 15
`define TSQ_CL_C2_EXEC 17
// ****************************************
// Encodings and reset values
// ****************************************
`define TSQ_UNIT_EVENTS 2'h0
`define TSQ_UNIT_US 2'h1
`define TSQ_UNIT_MS 2'h2
`define TSQ_ACT_RUN 2'h0
`define TSQ_ACT_STOP 2'h1
`define TSQ_ACT_RESET_RUN 2'h2
`define TSQ_POS_BEFORE 2'h0
`define TSQ_POS_CENTER 2'h1
`define TSQ_POS_AFTER 2'h2
`define TSQ_POS_ZERO 2'h3
`define TSQ_CFG_RESET 32'h0000_0000
// ****************************************
// Timing
// ****************************************
`define TSQ_CLK_PERIOD_NS 4
`define TSQ_US_NS 1000
`define TSQ_US_CYCLES (`TSQ_US_NS / `TSQ_CLK_PERIOD_NS)
`define TSQ_MS_US 1000
`define TSQ_POST_BEFORE 240
`define TSQ_POST_CENTER 128
`define TSQ_POST_AFTER 16
`define TSQ_POST_ZERO 1
`endif

// *** hw/tsq_pkg.sv ***
// Types shared by the trigger sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package tsq_pkg;
    // Sequencer run state
    typedef enum logic [1:0] {TSQ_IDLE, TSQ_ARMED, TSQ_POST, TSQ_DONE} tsq_state_t;
    // Sampled bus word: ext, inval, ba, rw, fetch, irq_n, nmi_n, addr, data
    typedef logic [30:0] tsq_bus_word_t;
endpackage
`default_nettype wire

// *** hw/tsq_count_unit.sv ***
// One event or time counter of the trigger sequencer.
// Assumes one-cycle command strobes and time ticks from the parent on hclk.
`include "tsq_regs.svh"
`default_nettype none
module tsq_count_unit #(
    parameter int WIDTH = 17
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clear,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_code,
    input wire logic [1:0] unit,
    input wire logic [WIDTH-1:0] cmp,
    input wire logic us_tick,
    input wire logic ms_tick,
    input wire logic freeze,
    output logic [WIDTH-1:0] value,
    output logic equal
);
    logic run_reg;
    logic tick;

    // Count reached its comparison value
    assign equal = (value == cmp);
    // Time base picked by the unit field
    assign tick = (unit == `TSQ_UNIT_US) ? us_tick : ((unit == `TSQ_UNIT_MS) ? ms_tick : 1'b0);

    // Run flag of a timed counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            run_reg <= 1'b0;
        else if (clear)
            run_reg <= 1'b0;
        else if (cmd_valid && !freeze && unit != `TSQ_UNIT_EVENTS)
            run_reg <= (cmd_code != `TSQ_ACT_STOP);
    end

    // Count value; a reset-and-run command wins over a tick in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            value <= '0;
        else if (clear)
            value <= '0;
        else if (freeze)
            value <= value;
        else if (cmd_valid && cmd_code == `TSQ_ACT_RESET_RUN)
            value <= '0;
        else if (cmd_valid && unit == `TSQ_UNIT_EVENTS && cmd_code == `TSQ_ACT_RUN && !equal)
            value <= value + 1'b1;
        else if (run_reg && tick && !equal)
            value <= value + 1'b1;
    end
endmodule
`default_nettype wire

// *** hw/tsq_sequencer.sv ***
// Trigger sequencer of a bus-monitoring logic analyzer, with an AHB-Lite register slave.
// Assumes the bus pins are asynchronous to hclk and are sampled on the rising edge of bus_clk.
`include "tsq_regs.svh"
`default_nettype none
// What this block does
// - Only clauses of the active test are evaluated.
// - Enabling match in test one starts the window counter and jumps.
// - The first satisfied clause acts; a repeated enable restarts the window from zero.
// - Window counter reaching its value jumps back to test one.
// - A compound action runs trigger, counter and jump commands together.
// - A test without clauses ignores input until the delay ends.
// - Acquisition ends when the post-trigger delay count completes, or at once on an abort.
// - A stopped counter holds its value until a run or reset-and-run command.
// - Running counters count until their value or acquisition end.
// - Trigger position selects the number of post-trigger cycles.
// - Zero delay ends acquisition on the cycle after the trigger.
// - Trigger memory index and active test are recorded and reported.
// - Counter-equals clause is true when the counter reaches its value.
// - In events mode each increment command adds one while the count is below its value.
// - Two independent counters, both drivable from one action.
// - Inversion makes its single event true when the match is false.
// - Inversion only inside brackets; double inversion rejects the program.
// - Interrupt qualifier fields are active low.
// - Counter unit: 0 events, 1 microseconds, 2 milliseconds.
// - Timed action: 0 run, 1 stop, 2 reset then run.
module tsq_sequencer #(
    parameter int MEM_AW = 8,
    parameter int CW = 17,
    parameter int POST_BEFORE = `TSQ_POST_BEFORE,
    parameter int POST_CENTER = `TSQ_POST_CENTER,
    parameter int POST_AFTER = `TSQ_POST_AFTER
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic bus_clk,
    input wire logic [7:0] bus_data,
    input wire logic [15:0] bus_addr,
    input wire logic bus_nmi_n,
    input wire logic bus_irq_n,
    input wire logic bus_fetch,
    input wire logic bus_rw,
    input wire logic bus_ba,
    input wire logic bus_inval,
    input wire logic bus_ext_trig,
    output logic trigger_pulse,
    output logic acq_end_pulse,
    output logic running,
    output logic acq_store,
    output logic [MEM_AW-1:0] acq_index
);
    localparam int NPAT = 4;
    localparam int NSLOT = 16;
    localparam logic [7:0] US_DIV = 8'(`TSQ_US_CYCLES - 1);
    localparam logic [9:0] MS_DIV = 10'(`TSQ_MS_US - 1);

    // ****************************************
    // Storage
    // ****************************************
    logic [31:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
    logic clk_prev_reg;
    logic [31:0] ctrl_reg, cfg1_reg, cfg2_reg;
    logic [31:0] pat_val_reg [NPAT];
    logic [31:0] pat_mask_reg [NPAT];
    logic [31:0] clause_reg [NSLOT];
    tsq_pkg::tsq_state_t state_reg;
    logic [1:0] active_reg, trig_test_reg;
    logic [MEM_AW-1:0] trig_idx_reg;
    logic [MEM_AW-1:0] post_cnt_reg;
    logic [7:0] us_cnt_reg;
    logic [9:0] ms_cnt_reg;
    logic us_tick_reg, ms_tick_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic start_reg, abort_reg;
    // ****************************************
    // Combinational
    // ****************************************
    tsq_pkg::tsq_bus_word_t bus_word;
    logic strobe, step, hit, prog_err, freeze, eq1, eq2;
    logic [31:0] act_word;
    logic [NPAT-1:0] pm;
    logic [CW-1:0] cnt1_val, cnt2_val;
    logic [MEM_AW-1:0] post_target;

    // Pattern compare of cared fields
    function automatic logic pat_match(input logic [30:0] bw, input logic [31:0] val, input logic [31:0] mask);
        pat_match = (((bw ^ val[30:0]) & mask[30:0]) == 31'h0000_0000);
    endfunction

    // One clause: selected event, optionally inverted
    function automatic logic clause_hit(input logic [31:0] cw, input logic [NPAT-1:0] p, input logic e1,
                                        input logic e2);
        logic raw;
        raw = 1'b0;
        unique case (cw[`TSQ_CL_SEL_LSB+:3])
            3'h0, 3'h1, 3'h2, 3'h3: raw = p[cw[`TSQ_CL_SEL_LSB+:2]];
            3'h4: raw = e1;
            3'h5: raw = e2;
            default: raw = 1'b0;
        endcase
        clause_hit = cw[`TSQ_CL_USED] & (raw ^ cw[`TSQ_CL_INV]);
    endfunction

    // Three-stage synchroniser with agreement filter on all pins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_reg <= 32'h0000_0000;
            sync2_reg <= 32'h0000_0000;
            sync3_reg <= 32'h0000_0000;
            filt_reg <= 32'h0000_0000;
            clk_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= {bus_clk, bus_ext_trig, bus_inval, bus_ba, bus_rw, bus_fetch, bus_irq_n, bus_nmi_n,
                          bus_addr, bus_data};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (filt_reg & (sync2_reg ^ sync3_reg));
            clk_prev_reg <= filt_reg[31];
        end
    end

    // Bus word and sampling strobe; interrupt bits kept at pin polarity
    assign bus_word = filt_reg[30:0];
    assign strobe = filt_reg[31] & ~clk_prev_reg;
    assign step = strobe && (state_reg == tsq_pkg::TSQ_ARMED || state_reg == tsq_pkg::TSQ_POST);
    assign freeze = !(state_reg == tsq_pkg::TSQ_ARMED || state_reg == tsq_pkg::TSQ_POST);

    // Pattern matcher outputs
    always_comb
    begin
        for (int i = 0; i < NPAT; i++)
            pm[i] = pat_match(bus_word, pat_val_reg[i], pat_mask_reg[i]);
    end

    // Active-test clauses only; first satisfied clause supplies the action
    always_comb
    begin
        hit = 1'b0;
        act_word = 32'h0000_0000;
        for (int c = 3; c >= 0; c--)
        begin
            if (clause_hit(clause_reg[{active_reg, 2'(c)}], pm, eq1, eq2))
            begin
                hit = 1'b1;
                act_word = clause_reg[{active_reg, 2'(c)}];
            end
        end
    end

    // Program check: lone or double inversion refuses the start
    always_comb
    begin
        prog_err = 1'b0;
        for (int k = 0; k < NSLOT; k++)
            prog_err = prog_err | (clause_reg[k][`TSQ_CL_USED] & ((clause_reg[k][`TSQ_CL_INV] &
                       ~clause_reg[k][`TSQ_CL_BRK]) | clause_reg[k][`TSQ_CL_DBL]));
    end

    // Post-trigger length from the trigger position
    always_comb
    begin
        unique case (ctrl_reg[`TSQ_CTRL_POS_LSB+:2])
            `TSQ_POS_BEFORE: post_target = MEM_AW'(POST_BEFORE);
            `TSQ_POS_CENTER: post_target = MEM_AW'(POST_CENTER);
            `TSQ_POS_AFTER: post_target = MEM_AW'(POST_AFTER);
            `TSQ_POS_ZERO: post_target = MEM_AW'(`TSQ_POST_ZERO);
        endcase
    end

    // Microsecond and millisecond tick dividers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            us_cnt_reg <= 8'h00;
            ms_cnt_reg <= 10'h000;
            us_tick_reg <= 1'b0;
            ms_tick_reg <= 1'b0;
        end
        else
        begin
            us_tick_reg <= (us_cnt_reg == US_DIV);
            us_cnt_reg <= (us_cnt_reg == US_DIV) ? 8'h00 : us_cnt_reg + 8'h01;
            ms_tick_reg <= us_tick_reg && (ms_cnt_reg == MS_DIV);
            if (us_tick_reg)
                ms_cnt_reg <= (ms_cnt_reg == MS_DIV) ? 10'h000 : ms_cnt_reg + 10'h001;
        end
    end

    // ****************************************
    // Counters
    // ****************************************
    tsq_count_unit #(.WIDTH(CW)) first_count_unit (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(start_reg),
        .cmd_valid(step && hit && act_word[`TSQ_CL_C1_EXEC]),
        .cmd_code(act_word[`TSQ_CL_C1_LSB+:2]),
        .unit(cfg1_reg[`TSQ_CFG_UNIT_LSB+:2]),
        .cmp(cfg1_reg[`TSQ_CFG_CMP_LSB+:CW]),
        .us_tick(us_tick_reg),
        .ms_tick(ms_tick_reg),
        .freeze(freeze),
        .value(cnt1_val),
        .equal(eq1)
    );
    tsq_count_unit #(.WIDTH(CW)) second_count_unit (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(start_reg),
        .cmd_valid(step && hit && act_word[`TSQ_CL_C2_EXEC]),
        .cmd_code(act_word[`TSQ_CL_C2_LSB+:2]),
        .unit(cfg2_reg[`TSQ_CFG_UNIT_LSB+:2]),
        .cmp(cfg2_reg[`TSQ_CFG_CMP_LSB+:CW]),
        .us_tick(us_tick_reg),
        .ms_tick(ms_tick_reg),
        .freeze(freeze),
        .value(cnt2_val),
        .equal(eq2)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    // Run state, trigger and end of acquisition
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= tsq_pkg::TSQ_IDLE;
            post_cnt_reg <= '0;
            trigger_pulse <= 1'b0;
            acq_end_pulse <= 1'b0;
        end
        else
        begin
            trigger_pulse <= 1'b0;
            acq_end_pulse <= 1'b0;
            if (abort_reg)
                state_reg <= tsq_pkg::TSQ_IDLE;
            else if (start_reg)
            begin
                state_reg <= tsq_pkg::TSQ_ARMED;
                post_cnt_reg <= '0;
            end
            else if (step)
            begin
                unique case (state_reg)
                    tsq_pkg::TSQ_ARMED:
                        if (hit && act_word[`TSQ_CL_TRIG])
                        begin
                            state_reg <= tsq_pkg::TSQ_POST;
                            trigger_pulse <= 1'b1;
                        end
                    tsq_pkg::TSQ_POST:
                    begin
                        post_cnt_reg <= post_cnt_reg + 1'b1;
                        if (post_cnt_reg + 1'b1 == post_target)
                        begin
                            state_reg <= tsq_pkg::TSQ_DONE;
                            acq_end_pulse <= 1'b1;
                        end
                    end
                    default: state_reg <= state_reg;
                endcase
            end
        end
    end

    // Active test: jump target loads for the next bus cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            active_reg <= 2'h0;
        else if (start_reg)
            active_reg <= 2'h0;
        else if (step && hit && act_word[`TSQ_CL_JUMP])
            active_reg <= act_word[`TSQ_CL_TGT_LSB+:2];
    end

    // Memory index, store strobe and trigger record
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acq_index <= '0;
            acq_store <= 1'b0;
            trig_idx_reg <= '0;
            trig_test_reg <= 2'h0;
        end
        else
        begin
            acq_store <= step;
            if (start_reg)
                acq_index <= '0;
            else if (acq_store)
                acq_index <= acq_index + 1'b1;
            if (step && state_reg == tsq_pkg::TSQ_ARMED && hit && act_word[`TSQ_CL_TRIG])
            begin
                trig_idx_reg <= acq_index;
                trig_test_reg <= active_reg;
            end
        end
    end
    assign running = (state_reg == tsq_pkg::TSQ_ARMED) || (state_reg == tsq_pkg::TSQ_POST);

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture and registered read data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
        end
        else if (hready)
        begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            wr_addr_reg <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite)
            begin
                hrdata <= 32'h0000_0000;
                unique case (haddr[7:0])
                    `TSQ_CTRL_OFS: hrdata <= {28'h000_0000, ctrl_reg[`TSQ_CTRL_POS_LSB+:2], 2'h0};
                    `TSQ_STAT_OFS: hrdata <= {8'h00, 8'(trig_idx_reg), 4'h0, 2'h0, trig_test_reg, 2'h0, active_reg,
                                              prog_err, state_reg == tsq_pkg::TSQ_DONE,
                                              state_reg == tsq_pkg::TSQ_POST, running};
                    `TSQ_CNT1_CFG_OFS: hrdata <= cfg1_reg;
                    `TSQ_CNT2_CFG_OFS: hrdata <= cfg2_reg;
                    `TSQ_CNT1_VAL_OFS: hrdata <= 32'(cnt1_val);
                    `TSQ_CNT2_VAL_OFS: hrdata <= 32'(cnt2_val);
                    default:
                        if (haddr[7:5] == 3'h1)
                            hrdata <= haddr[2] ? pat_mask_reg[haddr[4:3]] : pat_val_reg[haddr[4:3]];
                        else if (haddr[7:6] == 2'h1)
                            hrdata <= clause_reg[haddr[5:2]];
                endcase
            end
        end
    end

    // Data phase writes and start and abort pulses
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_reg <= `TSQ_CFG_RESET;
            cfg1_reg <= `TSQ_CFG_RESET;
            cfg2_reg <= `TSQ_CFG_RESET;
            start_reg <= 1'b0;
            abort_reg <= 1'b0;
            for (int i = 0; i < NPAT; i++)
            begin
                pat_val_reg[i] <= `TSQ_CFG_RESET;
                pat_mask_reg[i] <= `TSQ_CFG_RESET;
            end
            for (int k = 0; k < NSLOT; k++)
                clause_reg[k] <= `TSQ_CFG_RESET;
        end
        else
        begin
            start_reg <= 1'b0;
            abort_reg <= 1'b0;
            if (wr_pend_reg)
            begin
                unique case (wr_addr_reg)
                    `TSQ_CTRL_OFS:
                    begin
                        ctrl_reg <= hwdata;
                        start_reg <= hwdata[`TSQ_CTRL_START] && !prog_err;
                        abort_reg <= hwdata[`TSQ_CTRL_ABORT];
                    end
                    `TSQ_CNT1_CFG_OFS: cfg1_reg <= hwdata;
                    `TSQ_CNT2_CFG_OFS: cfg2_reg <= hwdata;
                    default:
                        if (wr_addr_reg[7:5] == 3'h1 && wr_addr_reg[2])
                            pat_mask_reg[wr_addr_reg[4:3]] <= hwdata;
                        else if (wr_addr_reg[7:5] == 3'h1)
                            pat_val_reg[wr_addr_reg[4:3]] <= hwdata;
                        else if (wr_addr_reg[7:6] == 2'h1)
                            clause_reg[wr_addr_reg[5:2]] <= hwdata;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/tsq_sequencer_asserts.sv ***
// Port checks of the trigger sequencer, bound into it.
// Assumes one hclk domain, hresetn active low.
`default_nettype none
module tsq_sequencer_asserts #(
    parameter int MEM_AW = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic trigger_pulse,
    input wire logic acq_end_pulse,
    input wire logic running,
    input wire logic acq_store,
    input wire logic [MEM_AW-1:0] acq_index
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************
    // Properties
    // ************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus answer late or not okay");
    property p_rdata; $changed(hrdata) |-> $past(hsel && htrans[1] && hready && !hwrite); endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved unread");
    property p_trig_run; trigger_pulse |-> running; endproperty
    a_trig_run: assert property (p_trig_run) else $error("trigger outside a run");
    property p_trig_once; trigger_pulse |=> !trigger_pulse [*8]; endproperty
    a_trig_once: assert property (p_trig_once) else $error("trigger repeated");
    property p_end_idle; acq_end_pulse |-> !running && $past(running); endproperty
    a_end_idle: assert property (p_end_idle) else $error("end without run stop");
    property p_store_run; acq_store |-> running || acq_end_pulse; endproperty
    a_store_run: assert property (p_store_run) else $error("store while idle");
    property p_store_gap; acq_store |=> !acq_store [*2]; endproperty
    a_store_gap: assert property (p_store_gap) else $error("cycle stored twice");
    property p_index;
        $changed(acq_index) && acq_index != '0 |-> $past(acq_store)
            && acq_index == $past(acq_index) + 1'b1;
    endproperty
    a_index: assert property (p_index) else $error("memory index jumped");
    c_trig: cover property (trigger_pulse);
    c_end: cover property (acq_end_pulse);
    c_store: cover property (acq_store ##[1:20] trigger_pulse);
endmodule
bind tsq_sequencer tsq_sequencer_asserts #(.MEM_AW(MEM_AW)) u_asserts (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trigger_pulse(trigger_pulse),
    .acq_end_pulse(acq_end_pulse), .running(running), .acq_store(acq_store), .acq_index(acq_index));
`default_nettype wire

// *** verification/tsq_bus_model.sv ***
// Behavioural model of the monitored processor bus.
// Assumes cycle is called after a rising hclk edge.
`default_nettype none
module tsq_bus_model (
    input wire logic hclk,
    output logic bus_clk,
    output var tsq_pkg::tsq_bus_word_t word
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************
    // Bus cycle driver
    // ************
    initial
    begin
        bus_clk = 1'b0;
        word = '0;
    end
    // Setup, clock high, clock low, stale word inverted
    task automatic cycle(input tsq_pkg::tsq_bus_word_t w);
        word <= w;
        repeat (4) @(posedge hclk);
        bus_clk <= 1'b1;
        repeat (4) @(posedge hclk);
        bus_clk <= 1'b0;
        repeat (4) @(posedge hclk);
        word <= ~w;
        @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// *** verification/tsq_sequencer_bench.sv ***
// Self-checking bench of the trigger sequencer.
// Assumes package, design and bus model compiled first.
`default_nettype none
module tsq_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ************
    // Stimulus and checking
    // ************
    localparam tsq_pkg::tsq_bus_word_t W_EN = 31'h0300_0600, W_HIT = 31'h03F8_2E00, W_FET = 31'h0400_0000;
    localparam logic [31:0] PAT [8] = '{32'h600, 32'hFFFF00, 32'hF82E00, 32'hFFFF00,
        32'h4000000, 32'h4000000, 32'h3000000, 32'h3000000};
    localparam int POST [4] = '{4, 4, 2, 1};
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'hDDBFEE3F, hrdata, r;
    logic hreadyout, hresp, bus_clk, trigger_pulse, acq_end_pulse, running, acq_store;
    logic [7:0] acq_index;
    tsq_pkg::tsq_bus_word_t word;
    int errors = 0, n_compared = 0, n_trig = 0, n_end = 0, cyc = 0, post, e0;
    tsq_sequencer #(.POST_BEFORE(4), .POST_CENTER(4), .POST_AFTER(2)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .bus_clk(bus_clk), .bus_data(word[7:0]), .bus_addr(word[23:8]),
        .bus_nmi_n(word[24]), .bus_irq_n(word[25]), .bus_fetch(word[26]), .bus_rw(word[27]),
        .bus_ba(word[28]), .bus_inval(word[29]), .bus_ext_trig(word[30]), .trigger_pulse(trigger_pulse),
        .acq_end_pulse(acq_end_pulse), .running(running), .acq_store(acq_store), .acq_index(acq_index));
    tsq_bus_model bm (.hclk(hclk), .bus_clk(bus_clk), .word(word));
    // Clock
    initial forever #2 hclk = ~hclk;
    // Pulse counts, run limit
    always @(posedge hclk)
    begin
        if (trigger_pulse === 1'b1) n_trig++;
        if (acq_end_pulse === 1'b1) n_end++;
        cyc++;
        if (cyc > 100000)
        begin
            errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string n, logic [31:0] s, e);
        n_compared++;
        if (s !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wait_rdy();
        repeat (64)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        errors++;
        report_and_stop();
    endtask
    // One AHB-Lite word transfer
    task automatic ahb(input logic w, logic [7:0] a, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask
    task automatic chk(input logic [7:0] a, logic [31:0] m, e, string n);
        ahb(1'b0, a, 32'h0);
        check(n, r & m, e);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Random word matching only pattern 3 (both interrupt pins high)
    function automatic tsq_pkg::tsq_bus_word_t noise();
        seed = xs(seed);
        return {5'h00, 2'h3, 4'h1, seed[11:0], seed[19:12]};
    endfunction
    // Main sequence
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        chk(8'h04, 32'hFFFF_FFFF, 32'h0, "status");
        chk(8'h80, 32'hFFFF_FFFF, 32'h0, "unmapped");
        for (int i = 0; i < 8; i++)
            ahb(1'b1, 8'h20 + 8'(4 * i), PAT[i]);
        ahb(1'b1, 8'h08, 32'h201);
        ahb(1'b1, 8'h40, 32'h6301);
        ahb(1'b1, 8'h50, 32'h5583);
        ahb(1'b1, 8'h54, 32'h6001);
        ahb(1'b1, 8'h58, 32'h109);
        ahb(1'b1, 8'h00, 32'h1);
        bm.cycle(W_HIT);
        chk(8'h04, 32'h30, 32'h0, "test");
        bm.cycle(W_EN);
        chk(8'h04, 32'h30, 32'h10, "test");
        repeat (70) bm.cycle(noise());
        chk(8'h04, 32'h30, 32'h0, "test");
        for (int i = 0; i < 3; i++)
        begin
            bm.cycle(W_EN);
            repeat (15) bm.cycle(noise());
            chk(8'h04, 32'h30, 32'h10, "test");
        end
        bm.cycle(W_HIT);
        chk(8'h04, 32'h330, 32'h120, "trig test");
        repeat (3) bm.cycle(W_EN);
        chk(8'h10, 32'h1FFFE, 32'h0, "window");
        bm.cycle(W_EN);
        check("end", n_end, 1);
        ahb(1'b1, 8'h08, 32'h500);
        ahb(1'b1, 8'h0C, 32'h1FFFF00);
        ahb(1'b1, 8'h40, 32'h24005);
        ahb(1'b1, 8'h44, 32'h89);
        for (int p = 0; p < 4; p++)
        begin
            ahb(1'b1, 8'h00, 32'(p * 4 + 1));
            repeat (5) bm.cycle(noise() | W_FET);
            bm.cycle(noise());
            e0 = n_end;
            post = 0;
            while (n_end == e0 && post < 20)
            begin
                bm.cycle(noise() | W_FET);
                post++;
            end
            check("post", post, POST[p]);
            chk(8'h10, 32'h1FFFF, 32'h5, "count1");
            chk(8'h14, 32'h1FFFF, 32'(5 + POST[p]), "count2");
            chk(8'h04, 32'hFF0000, 32'h50000, "index");
        end
        ahb(1'b1, 8'h40, 32'h17);
        chk(8'h04, 32'h8, 32'h8, "error");
        ahb(1'b1, 8'h40, 32'h77);
        chk(8'h04, 32'h8, 32'h8, "error");
        ahb(1'b1, 8'h40, 32'hB7);
        chk(8'h04, 32'h8, 32'h0, "error");
        ahb(1'b1, 8'h00, 32'h1);
        bm.cycle(noise());
        check("trig", n_trig, 5);
        bm.cycle(noise() & 31'h7DFF_FFFF);
        check("trig", n_trig, 6);
        report_and_stop();
    end
endmodule
`default_nettype wire
